//--- logic/flash_lock_pkg.sv
// Constants and types for the flash program/erase lock block.
// Assumes an 8-bit special-register port and a 16-bit data-move port.
package flash_lock_pkg;
  localparam logic [7:0] CTRL_ADDR = 8'h8F;
  localparam logic [7:0] KEY_ADDR = 8'hB7;
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic [7:0] ERASE_FILL = 8'hFF;
  localparam int PWE_BIT = 0;
  localparam int PEE_BIT = 1;
  localparam int ADDR_WIDTH = 16;
  localparam int PAGE_BITS = 9;

  typedef enum logic [1:0] {
    LOCK_LOCKED = 2'b00,
    LOCK_FIRST = 2'b01,
    LOCK_OPEN = 2'b10,
    LOCK_DEAD = 2'b11
  } lock_state_type;
endpackage

//--- logic/flash_key_if.sv
// Link between the register front end and the key lock machine.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface flash_key_if;
  import flash_lock_pkg::*;
  logic key_wr;
  logic [7:0] key_data;
  logic op_attempt;
  logic op_done;
  logic busy;
  lock_state_type state;
  modport ctrl(output key_wr, output key_data, output op_attempt,
               output op_done, input busy, input state);
  modport lock(input key_wr, input key_data, input op_attempt,
               input op_done, output busy, output state);
endinterface

//--- logic/flash_key_lock.sv
// Four-state key lock that opens flash for one write or erase.
// Assumes op_done pulses once when the flash array finishes an operation.
`timescale 1ns/10ps
module flash_key_lock (
  input wire logic core_clk,
  input wire logic rstn,
  flash_key_if.lock kif
);
  import flash_lock_pkg::*;

  lock_state_type state_q, state_d;
  logic busy_q, busy_d;

  assign kif.state = state_q;
  assign kif.busy = busy_q;

  always_comb begin
    state_d = state_q;
    busy_d = busy_q;
    if (busy_q && kif.op_done) begin
      state_d = LOCK_LOCKED;
      busy_d = 1'b0;
    end
    if (kif.op_attempt) begin
      if (state_q == LOCK_OPEN && !busy_q) begin
        busy_d = 1'b1;
      end else begin
        state_d = LOCK_DEAD;
        busy_d = 1'b0;
      end
    end else if (kif.key_wr) begin
      case (state_q)
        LOCK_LOCKED: begin
          if (kif.key_data == KEY_FIRST) begin
            state_d = LOCK_FIRST;
          end else begin
            state_d = LOCK_DEAD;
          end
        end
        LOCK_FIRST: begin
          if (kif.key_data == KEY_SECOND) begin
            state_d = LOCK_OPEN;
          end else begin
            state_d = LOCK_DEAD;
          end
        end
        LOCK_OPEN: state_d = LOCK_DEAD;
        LOCK_DEAD: state_d = LOCK_DEAD;
        default: state_d = LOCK_DEAD;
      endcase
    end
    if (state_q == LOCK_DEAD) begin
      state_d = LOCK_DEAD;
      busy_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= LOCK_LOCKED;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q <= busy_d;
    end
  end

  AST_DEAD_STICKS: assert property (
    @(posedge core_clk) disable iff (!rstn)
    state_q == LOCK_DEAD |=> state_q == LOCK_DEAD [*3])
    else $error("Permanent lock was left before reset.");

  AST_BAD_FIRST: assert property (
    @(posedge core_clk) disable iff (!rstn)
    state_q == LOCK_LOCKED && kif.key_wr && !kif.op_attempt &&
    kif.key_data != KEY_FIRST |=> state_q == LOCK_DEAD)
    else $error("Wrong first key did not lock flash.");

  AST_UNLOCK: assert property (
    @(posedge core_clk) disable iff (!rstn)
    state_q == LOCK_LOCKED && kif.key_wr && !kif.op_attempt &&
    kif.key_data == KEY_FIRST ##1 kif.key_wr && !kif.op_attempt &&
    kif.key_data == KEY_SECOND |=> state_q == LOCK_OPEN)
    else $error("Correct key pair did not unlock flash.");

  AST_RELOCK: assert property (
    @(posedge core_clk) disable iff (!rstn)
    busy_q && kif.op_done && !kif.op_attempt && state_q != LOCK_DEAD
    |=> state_q == LOCK_LOCKED && !busy_q)
    else $error("Lock did not return after the operation finished.");

  AST_LOCKED_ATTEMPT: assert property (
    @(posedge core_clk) disable iff (!rstn)
    kif.op_attempt && (state_q != LOCK_OPEN || busy_q)
    |=> state_q == LOCK_DEAD)
    else $error("Attempt while locked did not force permanent lock.");
endmodule // flash_key_lock

//--- logic/flash_program_erase_lock.sv
// Program-store control and key lock gating flash writes and page erases.
// Assumes the core, flash array and supply monitor share core_clk.
//
// Operation
// - Both enables set: a data-move write erases the addressed whole page.
// - Data byte of an erasing data-move write is ignored.
// - Erase enable bit 1 blocks erasure at 0, allows it at 1.
// - Write enable bit 0 at 1 routes data-move writes to flash programming.
// - Write enable at 0 means data-move writes never touch flash.
// - Only key 0xA5 then 0xF1 unlocks one flash operation.
// - After one write or erase completes the lock closes again.
// - A wrong key write locks flash permanently until reset.
// - A flash attempt while locked with the supply monitor armed also locks permanently until reset.
// - A first key other than 0xA5 deliberately locks flash.
// - Reading the key register returns lock state in bits 1-0.
// - State 00 means locked, 01 means first key accepted.
// - State 10 means unlocked, 11 means disabled until reset.
// - Erase fills the page with 0xFF; writes only clear bits.
// - Data-move reads always go to external data RAM.
// - Flash operation without supply monitor armed raises a flash error reset.
`timescale 1ns/10ps
module flash_program_erase_lock #(
  parameter int AW = flash_lock_pkg::ADDR_WIDTH,
  parameter int PAGE = flash_lock_pkg::PAGE_BITS
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic xdata_wr,
  input wire logic xdata_rd,
  input wire logic [AW-1:0] xdata_addr,
  input wire logic [7:0] xdata_wdata,
  input wire logic supply_mon_en,
  input wire logic supply_mon_reset_src,
  input wire logic flash_done,
  output logic flash_write,
  output logic flash_erase,
  output logic [AW-1:0] flash_addr,
  output logic [7:0] flash_data,
  output logic external_data_ram_wr,
  output logic external_data_ram_rd,
  output logic [AW-1:0] external_data_ram_addr,
  output logic [7:0] external_data_ram_data,
  output logic flash_error_reset
);
  import flash_lock_pkg::*;

  flash_key_if kif ();

  flash_key_lock u_lock (
    .core_clk(core_clk),
    .rstn(rstn),
    .kif(kif)
  );

  logic program_write_enable_q, program_write_enable_d;
  logic page_erase_enable_q, page_erase_enable_d;
  logic [7:0] rdata_q, rdata_d;
  logic fwr_q, fwr_d, fer_q, fer_d, err_q, err_d;
  logic [AW-1:0] faddr_q, faddr_d, xaddr_q, xaddr_d;
  logic [7:0] fdata_q, fdata_d, xdata_q, xdata_d;
  logic xwr_q, xwr_d, xrd_q, xrd_d;
  logic flash_target, supply_ok, grant;

  // Only the two enables are stored; the reserved bits have no flops,
  // so a stray pattern there cannot change behaviour.
  always_comb begin
    program_write_enable_d = program_write_enable_q;
    page_erase_enable_d = page_erase_enable_q;
    if (sfr_wr && sfr_addr == CTRL_ADDR) begin
      program_write_enable_d = sfr_wdata[PWE_BIT];
      page_erase_enable_d = sfr_wdata[PEE_BIT];
    end
  end

  always_comb begin
    kif.key_wr = sfr_wr && sfr_addr == KEY_ADDR;
    kif.key_data = sfr_wdata;
    kif.op_done = flash_done;
    flash_target = xdata_wr && program_write_enable_q;
    supply_ok = supply_mon_en && supply_mon_reset_src;
    kif.op_attempt = flash_target && supply_ok;
    grant = kif.op_attempt && kif.state == LOCK_OPEN && !kif.busy;
  end

  always_comb begin
    fwr_d = 1'b0;
    fer_d = 1'b0;
    err_d = flash_target && !supply_ok;
    faddr_d = faddr_q;
    fdata_d = fdata_q;
    if (grant) begin
      if (page_erase_enable_q) begin
        fer_d = 1'b1;
        faddr_d = {xdata_addr[AW-1:PAGE], {PAGE{1'b0}}};
        fdata_d = ERASE_FILL;
      end else begin
        fwr_d = 1'b1;
        faddr_d = xdata_addr;
        fdata_d = xdata_wdata;
      end
    end
    xwr_d = xdata_wr && !program_write_enable_q;
    xrd_d = xdata_rd;
    xaddr_d = (xdata_wr || xdata_rd) ? xdata_addr : xaddr_q;
    xdata_d = xwr_d ? xdata_wdata : xdata_q;
  end

  always_comb begin
    case (sfr_addr)
      CTRL_ADDR: rdata_d = {6'h00, page_erase_enable_q,
                             program_write_enable_q};
      KEY_ADDR: rdata_d = {6'h00, kif.state};
      default: rdata_d = READ_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      program_write_enable_q <= CTRL_RESET[PWE_BIT];
      page_erase_enable_q <= CTRL_RESET[PEE_BIT];
      rdata_q <= KEY_RESET;
      fwr_q <= 1'b0;
      fer_q <= 1'b0;
      err_q <= 1'b0;
      faddr_q <= '0;
      fdata_q <= ERASE_FILL;
      xwr_q <= 1'b0;
      xrd_q <= 1'b0;
      xaddr_q <= '0;
      xdata_q <= 8'h00;
    end else begin
      program_write_enable_q <= program_write_enable_d;
      page_erase_enable_q <= page_erase_enable_d;
      rdata_q <= rdata_d;
      fwr_q <= fwr_d;
      fer_q <= fer_d;
      err_q <= err_d;
      faddr_q <= faddr_d;
      fdata_q <= fdata_d;
      xwr_q <= xwr_d;
      xrd_q <= xrd_d;
      xaddr_q <= xaddr_d;
      xdata_q <= xdata_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign flash_write = fwr_q;
  assign flash_erase = fer_q;
  assign flash_addr = faddr_q;
  assign flash_data = fdata_q;
  assign external_data_ram_wr = xwr_q;
  assign external_data_ram_rd = xrd_q;
  assign external_data_ram_addr = xaddr_q;
  assign external_data_ram_data = xdata_q;
  assign flash_error_reset = err_q;

  AST_READ_STATE: assert property (
    @(posedge core_clk) disable iff (!rstn)
    sfr_addr == KEY_ADDR |=> sfr_rdata == {6'h00, $past(kif.state)})
    else $error("Key read did not return the lock state.");

  AST_ERASE: assert property (
    @(posedge core_clk) disable iff (!rstn)
    grant && page_erase_enable_q |=> flash_erase && !flash_write &&
    flash_addr[PAGE-1:0] == '0)
    else $error("Erase was not issued for the whole page.");

  AST_ERASE_DATA: assert property (
    @(posedge core_clk) disable iff (!rstn)
    flash_erase |-> flash_data == ERASE_FILL)
    else $error("Erase carried the data byte.");

  AST_WRITE: assert property (
    @(posedge core_clk) disable iff (!rstn)
    grant && !page_erase_enable_q |=> flash_write &&
    flash_addr == $past(xdata_addr) && flash_data == $past(xdata_wdata))
    else $error("Enabled data-move write did not program flash.");

  AST_NO_FLASH: assert property (
    @(posedge core_clk) disable iff (!rstn)
    xdata_wr && !program_write_enable_q |=> external_data_ram_wr &&
    !flash_write && !flash_erase)
    else $error("Data-move write reached flash with writes disabled.");

  AST_NO_ERASE: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !page_erase_enable_q |=> !flash_erase)
    else $error("Erase issued with erase disabled.");

  AST_READ_EXTERNAL_DATA_RAM: assert property (
    @(posedge core_clk) disable iff (!rstn)
    xdata_rd |=> external_data_ram_rd &&
    external_data_ram_addr == $past(xdata_addr))
    else $error("Data-move read did not reach external RAM.");

  AST_SUPPLY: assert property (
    @(posedge core_clk) disable iff (!rstn)
    flash_target && !(supply_mon_en && supply_mon_reset_src)
    |=> flash_error_reset && !flash_write && !flash_erase)
    else $error("Unprotected flash attempt gave no error reset.");

  AST_READ_CTRL: assert property (
    @(posedge core_clk) disable iff (!rstn)
    sfr_addr == CTRL_ADDR |=> sfr_rdata == {6'h00,
    $past(page_erase_enable_q), $past(program_write_enable_q)})
    else $error("Control read did not return the enable bits.");

  AST_LOCKED_NO_OP: assert property (
    @(posedge core_clk) disable iff (!rstn)
    flash_target && (kif.state != LOCK_OPEN || kif.busy)
    |=> !flash_write && !flash_erase)
    else $error("Flash operation issued while locked.");

  // A new operation needs a done pulse and two key writes, so at least
  // three quiet cycles must follow every issued operation.
  AST_ONE_OP: assert property (
    @(posedge core_clk) disable iff (!rstn)
    flash_write || flash_erase |=> (!flash_write && !flash_erase) [*3])
    else $error("Second flash operation followed without a new key.");
endmodule // flash_program_erase_lock

//--- tb/flash_array_model.sv
// Flash array stand-in that answers each write or erase with a done pulse.
// Assumes flash_write and flash_erase are one-cycle pulses on core_clk.
`timescale 1ns/10ps
module flash_array_model #(
  parameter int DELAY = 3
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic flash_write,
  input wire logic flash_erase,
  output logic flash_done
);
  int cnt;
  // A slow answer keeps the lock busy long enough to be seen.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      flash_done <= 1'b0;
    end else begin
      flash_done <= (cnt == 1);
      if (flash_write || flash_erase) begin
        cnt <= DELAY;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // flash_array_model

//--- tb/flash_program_erase_lock_bench.sv
// Bench for the flash lock block: register and data-move calls with checks.
// Assumes the flash array model answers every operation within 20 cycles.
`timescale 1ns/10ps
module flash_program_erase_lock_bench;
  import flash_lock_pkg::*;
  logic core_clk, rstn, sfr_wr, xdata_wr, xdata_rd, mon_en, flash_done;
  logic flash_write, flash_erase, ram_wr, ram_rd, err_rst, mon_src;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xdata_wdata, flash_data;
  logic [7:0] ram_data, v;
  logic [15:0] xdata_addr, flash_addr, ram_addr;
  int mismatches, total_checks, cycles, n_wr, n_er, n_rw, n_rr, n_err, n_dn;

  flash_program_erase_lock i_dut (.core_clk(core_clk), .rstn(rstn),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .xdata_wr(xdata_wr), .xdata_rd(xdata_rd),
    .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata),
    .supply_mon_en(mon_en), .supply_mon_reset_src(mon_src),
    .flash_done(flash_done), .flash_write(flash_write),
    .flash_erase(flash_erase), .flash_addr(flash_addr),
    .flash_data(flash_data), .external_data_ram_wr(ram_wr),
    .external_data_ram_rd(ram_rd), .external_data_ram_addr(ram_addr),
    .external_data_ram_data(ram_data), .flash_error_reset(err_rst));
  flash_array_model #(.DELAY(3)) i_flash (.core_clk(core_clk),
    .rstn(rstn), .flash_write(flash_write), .flash_erase(flash_erase),
    .flash_done(flash_done));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Pulses are counted here so that latency does not matter to the checks.
  always @(posedge core_clk) begin
    cycles++;
    n_wr += int'(flash_write === 1'b1);
    n_er += int'(flash_erase === 1'b1);
    n_rw += int'(ram_wr === 1'b1);
    n_rr += int'(ram_rd === 1'b1);
    n_err += int'(err_rst === 1'b1);
    n_dn += int'(flash_done === 1'b1);
    if (cycles == 3000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cnt(input string nm, input int e, g);
    total_checks++;
    if (g != e) begin
      mismatches++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic pulses(input int w, e, rw, rr, er);
    chk_cnt("flash_write", w, n_wr);
    chk_cnt("flash_erase", e, n_er);
    chk_cnt("ram_wr", rw, n_rw);
    chk_cnt("ram_rd", rr, n_rr);
    chk_cnt("flash_error_reset", er, n_err);
    {n_wr, n_er, n_rw, n_rr, n_err, n_dn} = '0;
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    @(posedge core_clk);
    #1 d = sfr_rdata;
  endtask

  task automatic key(input logic [1:0] e);
    rd(KEY_ADDR, v);
    chk("key state", {14'h0000, e}, {8'h00, v});
  endtask

  task automatic unlock();
    wr(KEY_ADDR, KEY_FIRST);
    wr(KEY_ADDR, KEY_SECOND);
  endtask

  task automatic mv(input logic [15:0] a, input logic [7:0] d, input logic r);
    @(posedge core_clk);
    xdata_wr <= !r;
    xdata_rd <= r;
    xdata_addr <= a;
    xdata_wdata <= d;
    @(posedge core_clk);
    {xdata_wr, xdata_rd} <= 2'b00;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic wait_done();
    for (int i = 0; i < 20 && n_dn == 0; i++) @(posedge core_clk);
    @(posedge core_clk);
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    {n_wr, n_er, n_rw, n_rr, n_err, n_dn} = '0;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    {sfr_wr, xdata_wr, xdata_rd, rstn} = '0;
    {sfr_addr, sfr_wdata, xdata_wdata, xdata_addr} = '0;
    {mon_en, mon_src} = 2'b11;
    do_reset();
    rd(CTRL_ADDR, v);
    chk("control", 16'h0000, {8'h00, v});
    key(2'b00);
    wr(CTRL_ADDR, 8'h03);
    rd(CTRL_ADDR, v);
    chk("control", 16'h0003, {8'h00, v});
    wr(KEY_ADDR, KEY_FIRST);
    key(2'b01);
    wr(KEY_ADDR, KEY_SECOND);
    key(2'b10);
    mv(16'h1234, 8'h5A, 1'b0);
    pulses(0, 1, 0, 0, 0);
    chk("erase addr", 16'h1234 & ~((16'h0001 << PAGE_BITS) - 16'h0001),
        flash_addr);
    chk("erase data", 16'h00FF, {8'h00, flash_data});
    wait_done();
    key(2'b00);
    // The erased byte is now programmed, as software is expected to do.
    wr(CTRL_ADDR, 8'h01);
    unlock();
    mv(16'h1234, 8'h5A, 1'b0);
    pulses(1, 0, 0, 0, 0);
    chk("write addr", 16'h1234, flash_addr);
    chk("write data", 16'h005A, {8'h00, flash_data});
    wait_done();
    key(2'b00);
    wr(CTRL_ADDR, 8'h02);
    mv(16'h0040, 8'h3C, 1'b0);
    pulses(0, 0, 1, 0, 0);
    chk("ram data", 16'h003C, {8'h00, ram_data});
    key(2'b00);
    wr(CTRL_ADDR, 8'h01);
    mv(16'h0080, 8'h00, 1'b1);
    pulses(0, 0, 0, 1, 0);
    chk("ram addr", 16'h0080, ram_addr);
    @(posedge core_clk);
    mon_en <= 1'b0;
    unlock();
    mv(16'h1234, 8'h5A, 1'b0);
    pulses(0, 0, 0, 0, 1);
    key(2'b10);
    // Monitor on but not chosen as a reset source is just as unsafe.
    @(posedge core_clk);
    {mon_en, mon_src} <= 2'b10;
    mv(16'h1234, 8'h5A, 1'b0);
    pulses(0, 0, 0, 0, 1);
    key(2'b10);
    @(posedge core_clk);
    mon_src <= 1'b1;
    wr(KEY_ADDR, KEY_FIRST);
    key(2'b11);
    mv(16'h1234, 8'h5A, 1'b0);
    pulses(0, 0, 0, 0, 0);
    do_reset();
    rd(CTRL_ADDR, v);
    chk("control", 16'h0000, {8'h00, v});
    wr(CTRL_ADDR, 8'h01);
    mv(16'h2000, 8'h11, 1'b0);
    pulses(0, 0, 0, 0, 0);
    key(2'b11);
    do_reset();
    wr(KEY_ADDR, 8'h12);
    key(2'b11);
    do_reset();
    wr(KEY_ADDR, KEY_FIRST);
    wr(KEY_ADDR, KEY_FIRST);
    key(2'b11);
    // A second write while the first is still pending must be refused.
    do_reset();
    wr(CTRL_ADDR, 8'h01);
    unlock();
    mv(16'h0300, 8'h77, 1'b0);
    mv(16'h0301, 8'h66, 1'b0);
    pulses(1, 0, 0, 0, 0);
    key(2'b11);
    finish_test();
  end
endmodule // flash_program_erase_lock_bench
